// ### hw/sfleb_ctrl.sv
// serial flash command latch, error flag, ecc status read and boot stream
// assumes sck_i only toggles while cs_n_i is low and idles for 4 sys cycles between frames
//
// How it works
// - set-latch opcode sets the write latch
// - write commands granted only while latch set
// - set-latch runs only if frame ends at bit eight
// - clear-latch opcode clears the write latch
// - clear-latch runs only if frame ends at eight
// - clear-latch ignored while an operation is busy
// - clear-errors opcode clears erase and program fail
// - clear-errors needs no latch, keeps latch value
// - clear-errors accepted even while busy
// - eight dummy edges, then unit status sixteen times
// - holding select low walks to following units
// - any reset leaves the boot stream armed
// - boot output held back for the delay count
// - boot start address is 512-byte aligned, default zero
// - boot delay is an eight-bit count
// - boot streams ascending addresses until select rises
// - once the second byte starts, select high ends boot
// - boot never rearms without another reset
// - boot only when enable bit set, config reset to default
// - quad select chooses four-bit or one-bit boot data
// - register write completion clears the latch
// - opcode shifted one bit per rising clock
// - boot config word is thirty-two bits wide
`timescale 1ns/1ps
`include "sfleb_defines.svh"
module sfleb_ctrl (
  // system clock and control
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // serial link
  input  wire logic                     sck_i,
  input  wire logic                     cs_n_i,
  input  wire logic [3:0]               io_i,
  output logic      [3:0]               io_o,
  output logic      [3:0]               io_oe_o,
  // status and embedded operation events
  input  wire logic                     write_in_progress_i,
  input  wire logic                     erase_fail_set_i,
  input  wire logic                     program_fail_set_i,
  input  wire logic                     reg_write_done_i,
  output logic      [7:0]               status_reg_one_o,
  // write command gate
  input  wire logic                     write_cmd_req_i,
  output logic                          write_cmd_grant_o,
  output logic                          write_cmd_refuse_o,
  // configuration
  input  wire logic [7:0]               config_reg_one_i,
  input  wire logic                     boot_cfg_load_i,
  input  wire logic [31:0]              boot_cfg_i,
  input  wire logic                     soft_reset_req_i,
  output logic      [31:0]              boot_read_config_o,
  output logic                          boot_armed_o,
  // array read port, link clock
  output logic      [31:0]              array_rd_addr_o,
  input  wire logic [7:0]               array_rd_data_i,
  // ecc status store writes
  input  wire logic                     ecc_wr_en_i,
  input  wire logic [`SFLEB_UNIT_W-1:0] ecc_wr_unit_i,
  input  wire logic [7:0]               ecc_wr_status_i
);
  import sfleb_pkg::*;

  localparam sfleb_frame_t  FRAME_RST  = '0;
  localparam sfleb_result_t RESULT_RST = '0;

  sfleb_frame_t  fq;
  sfleb_frame_t  fn;
  sfleb_result_t rq;
  sfleb_result_t rn;
  sfleb_sys_t    sq;
  sfleb_sys_t    sn;
  sfleb_sys_t    sys_rst;

  logic        frame_rst;
  logic        frame_done;
  logic        boot_go;
  logic [7:0]  boot_delay;
  logic [31:0] boot_base;
  logic [7:0]  ecc_rdata;
  logic [7:0]  src;
  logic        quad_now;
  logic        take;

  // one-byte opcodes that act at frame end
  function automatic sfleb_cmd_t opc_decode(input logic [7:0] opc);
    case (opc)
      `SFLEB_OPC_SET_LATCH: opc_decode = CMD_SET_LATCH;
      `SFLEB_OPC_CLR_LATCH: opc_decode = CMD_CLR_LATCH;
      `SFLEB_OPC_CLR_ERR:   opc_decode = CMD_CLR_ERR;
      default:              opc_decode = CMD_NONE;
    endcase
  endfunction

  // lane mapping: serial data rides io[1], quad uses all four
  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic q);
    lane_out = q ? b[7:4] : {2'b00, b[7], 1'b0};
  endfunction

  // chip select high ends the frame; frame logic needs no sck edge to clear
  assign frame_rst = cs_n_i | rst_i;

  // boot settings are static while a frame is open
  assign boot_go    = sq.armed & sq.boot_cfg[`SFLEB_BCFG_EN_BIT];
  assign boot_delay = sq.boot_cfg[`SFLEB_BCFG_DLY_MSB:`SFLEB_BCFG_DLY_LSB];
  assign boot_base  = {sq.boot_cfg[`SFLEB_BCFG_ADDR_MSB:`SFLEB_BCFG_ADDR_LSB],
                       `SFLEB_BOOT_ALIGN_ZERO};

  sfleb_ecc_mem u_ecc_mem (
    .clk_sys_i (clk_sys_i),
    .wr_en_i   (ecc_wr_en_i & ce_i),
    .wr_addr_i (ecc_wr_unit_i),
    .wr_data_i (ecc_wr_status_i),
    .clk_rd_i  (sck_i),
    .rd_addr_i (fq.unit),
    .rd_data_o (ecc_rdata)
  );

  // link next state: decode, address, dummy and output phases
  always_comb begin
    fn       = fq;
    rn       = rq;
    src      = fq.sh;
    quad_now = 1'b0;
    take     = 1'b0;
    fn.began = 1'b1;
    // each clocked frame announces itself with one toggle
    if (!fq.began) begin
      rn.seq_tgl   = ~rq.seq_tgl;
      rn.cmd       = CMD_NONE;
      rn.boot_used = 1'b0;
    end
    case (fq.phase)
      PH_OPCODE: begin
        if (!fq.began && boot_go) begin
          fn.phase = PH_BOOT_WAIT;
          fn.cnt   = boot_delay;
          fn.baddr = boot_base;
        end else begin
          fn.opc = {fq.opc[6:0], io_i[0]};
          fn.cnt = fq.cnt + `SFLEB_CNT_ONE;
          if (fq.cnt == `SFLEB_OPC_LAST) begin
            rn.cmd   = opc_decode(fn.opc);
            fn.cnt   = '0;
            fn.phase = (fn.opc == `SFLEB_OPC_ECC_READ) ? PH_ADDR : PH_IGNORE;
          end
        end
      end
      PH_ADDR: begin
        fn.addr = {fq.addr[30:0], io_i[0]};
        fn.cnt  = fq.cnt + `SFLEB_CNT_ONE;
        if (fq.cnt == `SFLEB_ADDR_LAST) begin
          // low nibble is the byte within the unit and is dropped
          fn.unit  = fn.addr[`SFLEB_UNIT_LSB +: `SFLEB_UNIT_W];
          fn.cnt   = '0;
          fn.phase = PH_DUMMY;
        end
      end
      PH_DUMMY: begin
        fn.cnt = fq.cnt + `SFLEB_CNT_ONE;
        if (fq.cnt == `SFLEB_DUMMY_LAST) begin
          fn.phase = PH_ECC_OUT;
          take     = 1'b1;
        end
      end
      PH_ECC_OUT: take = (fq.left == '0);
      PH_BOOT_WAIT: begin
        if (fq.cnt == '0) begin
          fn.phase = PH_BOOT_OUT;
          take     = 1'b1;
        end else begin
          fn.cnt = fq.cnt - `SFLEB_CNT_ONE;
        end
      end
      PH_BOOT_OUT: take = (fq.left == '0);
      PH_IGNORE: begin
        // any edge past the eighth cancels a one-byte command
        rn.cmd = CMD_NONE;
      end
      default: fn.phase = PH_IGNORE;
    endcase
    // shared output stage; outputs stay released in all other phases
    if (fn.phase == PH_ECC_OUT || fn.phase == PH_BOOT_OUT) begin
      quad_now = (fn.phase == PH_BOOT_OUT) && sq.quad;
      if (take) begin
        if (fn.phase == PH_ECC_OUT) begin
          src = ecc_rdata;
          if (fq.bytes == `SFLEB_ECC_REP_LAST)
            fn.unit = fq.unit + 8'h01;
        end else begin
          src      = array_rd_data_i;
          fn.baddr = fq.baddr + 32'h0000_0001;
          if (fq.bytes != '0)
            rn.boot_used = 1'b1;
        end
        fn.bytes = fq.bytes + 4'h1;
        fn.left  = quad_now ? `SFLEB_QUAD_LAST : `SFLEB_SER_LAST;
      end else begin
        fn.left = fq.left - 3'h1;
      end
      fn.dout = lane_out(src, quad_now);
      fn.sh   = quad_now ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
      fn.doe  = quad_now ? `SFLEB_OE_QUAD : `SFLEB_OE_SER;
    end else begin
      fn.doe = `SFLEB_OE_OFF;
    end
  end

  // frame state, released by chip select high
  always_ff @(posedge sck_i or posedge frame_rst) begin
    if (frame_rst)
      fq <= FRAME_RST;
    else
      fq <= fn;
  end

  // frame results survive chip select so the system side can read them
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i)
      rq <= RESULT_RST;
    else
      rq <= rn;
  end

  // link outputs and array address straight from flops
  assign io_o            = fq.dout;
  assign io_oe_o         = fq.doe;
  assign array_rd_addr_o = fq.baddr;

  // system reset value; boot armed after any reset
  always_comb begin
    sys_rst          = '0;
    sys_rst.cs_s1    = 1'b1;
    sys_rst.cs_s2    = 1'b1;
    sys_rst.cs_s3    = 1'b1;
    sys_rst.armed    = 1'b1;
    sys_rst.boot_cfg = `SFLEB_BCFG_DEFAULT;
  end

  // result words are quiet once the synced select edge is seen
  assign frame_done = sq.cs_s2 & ~sq.cs_s3 & (sq.tgl_s2 != sq.seen);

  // system next state; hardware sets win over command clears
  always_comb begin
    sn = sq;
    if (ce_i) begin
      sn.cs_s1  = cs_n_i;
      sn.cs_s2  = sq.cs_s1;
      sn.cs_s3  = sq.cs_s2;
      sn.tgl_s1 = rq.seq_tgl;
      sn.tgl_s2 = sq.tgl_s1;
      sn.busy   = write_in_progress_i;
      sn.quad   = config_reg_one_i[`SFLEB_CFG_QUAD_BIT];
      if (boot_cfg_load_i)
        sn.boot_cfg = boot_cfg_i;
      if (reg_write_done_i)
        sn.latch = 1'b0;
      if (frame_done) begin
        sn.seen = sq.tgl_s2;
        case (rq.cmd)
          CMD_SET_LATCH: sn.latch = 1'b1;
          CMD_CLR_LATCH: begin
            if (!write_in_progress_i)
              sn.latch = 1'b0;
          end
          CMD_CLR_ERR: begin
            // no latch or busy gating here
            sn.efail = 1'b0;
            sn.pfail = 1'b0;
          end
          default: ;
        endcase
        if (rq.boot_used)
          sn.armed = 1'b0;
      end
      if (soft_reset_req_i)
        sn.armed = 1'b1;
      if (erase_fail_set_i)
        sn.efail = 1'b1;
      if (program_fail_set_i)
        sn.pfail = 1'b1;
    end
    if (rst_i)
      sn = sys_rst;
  end

  // system state register
  always_ff @(posedge clk_sys_i) begin
    sq <= sn;
  end

  // status and config views
  always_comb begin
    status_reg_one_o                        = 8'h00;
    status_reg_one_o[`SFLEB_STAT_BUSY_BIT]  = sq.busy;
    status_reg_one_o[`SFLEB_STAT_LATCH_BIT] = sq.latch;
    status_reg_one_o[`SFLEB_STAT_EFAIL_BIT] = sq.efail;
    status_reg_one_o[`SFLEB_STAT_PFAIL_BIT] = sq.pfail;
  end
  assign boot_read_config_o = sq.boot_cfg;
  assign boot_armed_o       = sq.armed;

  // write gate is combinational so the requester sees it the same cycle
  assign write_cmd_grant_o  = write_cmd_req_i & sq.latch;
  assign write_cmd_refuse_o = write_cmd_req_i & ~sq.latch;

  // system side checks
  a_set_latch_exec: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && frame_done && rq.cmd == CMD_SET_LATCH |=> sq.latch)
    else $error("set-latch frame did not set latch");
  a_clr_latch_exec: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && frame_done && rq.cmd == CMD_CLR_LATCH && !write_in_progress_i |=> !sq.latch)
    else $error("clear-latch frame did not clear latch");
  a_clr_latch_busy: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && frame_done && rq.cmd == CMD_CLR_LATCH && write_in_progress_i
      && !reg_write_done_i |=> $stable(sq.latch))
    else $error("clear-latch acted while busy");
  a_clr_err_flags: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && frame_done && rq.cmd == CMD_CLR_ERR && !erase_fail_set_i
      && !program_fail_set_i |=> !sq.efail && !sq.pfail)
    else $error("clear-errors left a fail flag");
  a_clr_err_latch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && frame_done && rq.cmd == CMD_CLR_ERR && !reg_write_done_i |=> $stable(sq.latch))
    else $error("clear-errors changed latch");
  a_grant_latch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    write_cmd_grant_o |-> sq.latch && !write_cmd_refuse_o)
    else $error("write granted without latch");
  a_done_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && reg_write_done_i && !(frame_done && rq.cmd == CMD_SET_LATCH) |=> !sq.latch)
    else $error("register write completion kept latch");
  a_boot_disarm: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && frame_done && rq.boot_used && !soft_reset_req_i |=> !sq.armed [*2])
    else $error("boot stayed armed after consumed frame");

  // link side checks
  a_ninth_cancels: assert property (@(posedge sck_i) disable iff (frame_rst)
    fq.phase == PH_IGNORE |=> rq.cmd == CMD_NONE)
    else $error("one-byte command survived extra edge");
  a_dummy_hiz: assert property (@(posedge sck_i) disable iff (frame_rst)
    fq.phase == PH_DUMMY || fq.phase == PH_BOOT_WAIT |-> fq.doe == `SFLEB_OE_OFF)
    else $error("output driven during delay or dummy");
  a_ecc_start: assert property (@(posedge sck_i) disable iff (frame_rst)
    fq.phase == PH_ADDR && fq.cnt == `SFLEB_ADDR_LAST |=> ##8 fq.phase == PH_ECC_OUT
      && fq.doe == `SFLEB_OE_SER)
    else $error("ecc status not driven after eight dummy edges");
  a_boot_wait: assert property (@(posedge sck_i) disable iff (frame_rst)
    fq.phase == PH_BOOT_WAIT && fq.cnt != '0 |=> fq.phase == PH_BOOT_WAIT)
    else $error("boot output started before delay ran out");

  c_set_latch: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    frame_done && rq.cmd == CMD_SET_LATCH);
  c_clr_err: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    frame_done && rq.cmd == CMD_CLR_ERR);
  c_boot_used: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    frame_done && rq.boot_used);
  c_ecc_next_unit: cover property (@(posedge sck_i) disable iff (frame_rst)
    fq.phase == PH_ECC_OUT && take && fq.bytes == `SFLEB_ECC_REP_LAST);
endmodule // sfleb_ctrl

// ### hw/sfleb_defines.svh
// named constants of the flash command latch / ecc / boot block
// assumes inclusion by its bare name from every design file that needs it
`ifndef SFLEB_DEFINES_SVH
`define SFLEB_DEFINES_SVH

// instruction codes
`define SFLEB_OPC_SET_LATCH   8'h06
`define SFLEB_OPC_CLR_LATCH   8'h04
`define SFLEB_OPC_CLR_ERR     8'h30
`define SFLEB_OPC_ECC_READ    8'h18

// status register one bit positions
`define SFLEB_STAT_BUSY_BIT   0
`define SFLEB_STAT_LATCH_BIT  1
`define SFLEB_STAT_EFAIL_BIT  5
`define SFLEB_STAT_PFAIL_BIT  6

// config register one quad select bit
`define SFLEB_CFG_QUAD_BIT    1

// boot configuration word layout and default
`define SFLEB_BCFG_EN_BIT     0
`define SFLEB_BCFG_DLY_LSB    1
`define SFLEB_BCFG_DLY_MSB    8
`define SFLEB_BCFG_ADDR_LSB   9
`define SFLEB_BCFG_ADDR_MSB   31
`define SFLEB_BCFG_DEFAULT    32'h0000_0000
`define SFLEB_BOOT_ALIGN_ZERO 9'h000

// link phase counts, last index of each phase
`define SFLEB_OPC_LAST        8'h07
`define SFLEB_ADDR_LAST       8'h1f
`define SFLEB_DUMMY_LAST      8'h07
`define SFLEB_ECC_REP_LAST    4'hf
`define SFLEB_SER_LAST        3'h7
`define SFLEB_QUAD_LAST       3'h1
`define SFLEB_CNT_ONE         8'h01

// ecc unit addressing and storage
`define SFLEB_UNIT_LSB        4
`define SFLEB_UNIT_W          8
`define SFLEB_UNIT_DEPTH      256

// output enables per mode
`define SFLEB_OE_SER          4'h2
`define SFLEB_OE_QUAD         4'hf
`define SFLEB_OE_OFF          4'h0

`endif

// ### hw/sfleb_pkg.sv
// types shared by the flash command latch / ecc / boot block
// assumes sfleb_defines.svh is on the include path
package sfleb_pkg;

  // decoded one-byte commands handed from link to system side
  typedef enum logic [1:0] {
    CMD_NONE      = 2'b00,
    CMD_SET_LATCH = 2'b01,
    CMD_CLR_LATCH = 2'b10,
    CMD_CLR_ERR   = 2'b11
  } sfleb_cmd_t;

  // link frame phases
  typedef enum logic [2:0] {
    PH_OPCODE    = 3'b000,
    PH_ADDR      = 3'b001,
    PH_DUMMY     = 3'b010,
    PH_ECC_OUT   = 3'b011,
    PH_BOOT_WAIT = 3'b100,
    PH_BOOT_OUT  = 3'b101,
    PH_IGNORE    = 3'b110
  } sfleb_phase_t;

  // per-frame link state, cleared whenever chip select is high
  typedef struct packed {
    logic         began;
    sfleb_phase_t phase;
    logic [7:0]   cnt;
    logic [7:0]   opc;
    logic [31:0]  addr;
    logic [7:0]   unit;
    logic [3:0]   bytes;
    logic [2:0]   left;
    logic [7:0]   sh;
    logic [31:0]  baddr;
    logic [3:0]   dout;
    logic [3:0]   doe;
  } sfleb_frame_t;

  // link results that outlive the frame
  typedef struct packed {
    logic       seq_tgl;
    sfleb_cmd_t cmd;
    logic       boot_used;
  } sfleb_result_t;

  // system clock state
  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_s3;
    logic        tgl_s1;
    logic        tgl_s2;
    logic        seen;
    logic        latch;
    logic        efail;
    logic        pfail;
    logic        busy;
    logic        quad;
    logic        armed;
    logic [31:0] boot_cfg;
  } sfleb_sys_t;

endpackage

// ### hw/sfleb_ecc_mem.sv
// ecc status store, one byte per ecc unit
// written on the system clock, read on the link clock with registered data
`timescale 1ns/1ps
`include "sfleb_defines.svh"
module sfleb_ecc_mem (
  // write side
  input  wire logic                     clk_sys_i,
  input  wire logic                     wr_en_i,
  input  wire logic [`SFLEB_UNIT_W-1:0] wr_addr_i,
  input  wire logic [7:0]               wr_data_i,
  // read side
  input  wire logic                     clk_rd_i,
  input  wire logic [`SFLEB_UNIT_W-1:0] rd_addr_i,
  output logic      [7:0]               rd_data_o
);
  import sfleb_pkg::*;

  logic [7:0] mem [`SFLEB_UNIT_DEPTH];

  // write port, system domain
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // read port, one link edge of latency
  always_ff @(posedge clk_rd_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // sfleb_ecc_mem

// ### tb/sfleb_host_model.sv
// host side model: spi controller that frames commands and clocks the link
// assumes the bench calls one task at a time and feeds back the resolved io wires
`timescale 1ns/1ps
module sfleb_host_model (
  // link towards the device
  output logic            sck_o,
  output logic            cs_n_o,
  output logic            si_o,
  // device answer, already resolved against release
  input  wire logic [3:0] io_i,
  input  wire logic [3:0] io_oe_i
);
  // 64 ns period keeps far below every boot speed limit
  localparam time HALF = 32ns;

  // link clock stands still low outside frames
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // one rising edge; answer sampled just before it, launched on the previous edge
  task automatic bit_edge(input logic drive, input logic b,
                          output logic [3:0] s, output logic [3:0] oe);
    si_o = drive ? b : ~si_o;
    #(HALF);
    s     = io_i;
    oe    = io_oe_i;
    sck_o = 1'b1;
    #(HALF);
    sck_o = 1'b0;
  endtask

  // odd offset so frames do not line up with the system clock
  task automatic begin_frame();
    #7ns;
    cs_n_o = 1'b0;
    #(HALF);
  endtask

  // select stays high long enough for the system side to see it
  task automatic end_frame();
    #(HALF);
    cs_n_o = 1'b1;
    #700ns;
  endtask

  // opcode and address bits, most significant first, one per edge
  task automatic send(input logic [39:0] v, input int n);
    logic [3:0] s;
    logic [3:0] oe;
    for (int i = n - 1; i >= 0; i--) begin
      bit_edge(1'b1, v[i], s, oe);
    end
  endtask
endmodule // sfleb_host_model

// ### tb/serial_flash_latch_ecc_boot_ctrl_tb.sv
// self-checking bench of the command latch, ecc status read and boot stream
// assumes sfleb_defines.svh on the include path and the host model alongside
`timescale 1ns/1ps
`include "sfleb_defines.svh"
module serial_flash_latch_ecc_boot_ctrl_tb;
  // system side stimulus
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        write_in_progress       = 1'b0;
  logic        efail_set = 1'b0;
  logic        pfail_set = 1'b0;
  logic        rwdone    = 1'b0;
  logic        req       = 1'b0;
  logic        cfg_load  = 1'b0;
  logic        soft_rst  = 1'b0;
  logic        ce        = 1'b1;
  logic        ecc_we    = 1'b0;
  logic [7:0]  cr1       = 8'h00;
  logic [7:0]  ecc_unit  = 8'h00;
  logic [7:0]  ecc_stat  = 8'h00;
  logic [31:0] bcfg      = 32'h0000_0000;
  logic [3:0]  io_rel    = 4'h5;
  // link and device outputs
  wire         sck;
  wire         cs_n;
  wire         si;
  wire  [3:0]  io_out;
  wire  [3:0]  io_oe;
  wire  [3:0]  io_wire;
  wire  [7:0]  sr1;
  wire         grant;
  wire         refuse;
  wire  [31:0] bcfg_rd;
  wire         armed;
  wire  [31:0] arr_addr;
  wire  [7:0]  arr_data;
  // bookkeeping
  int          bad_count = 0;
  int          checked   = 0;
  int          cyc       = 0;
  logic [7:0]  exp_q[$];
  logic [7:0]  got_byte;
  logic [7:0]  st[2];
  logic [7:0]  u;
  event        byte_ev;

  // array contents as a plain address hash
  function automatic logic [7:0] arr_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  always #50 clk_sys_i = ~clk_sys_i;
  // released lines flip every cycle so a stale value cannot pass
  always @(posedge clk_sys_i) io_rel <= ~io_rel;
  assign io_wire[0] = io_oe[0] ? io_out[0] : io_rel[0];
  assign io_wire[1] = io_oe[1] ? io_out[1] : io_rel[1];
  assign io_wire[2] = io_oe[2] ? io_out[2] : io_rel[2];
  assign io_wire[3] = io_oe[3] ? io_out[3] : io_rel[3];
  assign arr_data   = arr_byte(arr_addr);

  sfleb_ctrl sfleb_ctrl_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
    .sck_i(sck), .cs_n_i(cs_n), .io_i({3'b000, si}), .io_o(io_out), .io_oe_o(io_oe),
    .write_in_progress_i(write_in_progress), .erase_fail_set_i(efail_set),
    .program_fail_set_i(pfail_set), .reg_write_done_i(rwdone), .status_reg_one_o(sr1),
    .write_cmd_req_i(req), .write_cmd_grant_o(grant), .write_cmd_refuse_o(refuse),
    .config_reg_one_i(cr1), .boot_cfg_load_i(cfg_load), .boot_cfg_i(bcfg),
    .soft_reset_req_i(soft_rst), .boot_read_config_o(bcfg_rd), .boot_armed_o(armed),
    .array_rd_addr_o(arr_addr), .array_rd_data_i(arr_data),
    .ecc_wr_en_i(ecc_we), .ecc_wr_unit_i(ecc_unit), .ecc_wr_status_i(ecc_stat)
  );

  sfleb_host_model sfleb_host_model_inst (
    .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .io_i(io_wire), .io_oe_i(io_oe)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic sys_wait(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // whole one-frame command, then time for the sync and decode
  task automatic cmd(input logic [39:0] v, input int n);
    sfleb_host_model_inst.begin_frame();
    sfleb_host_model_inst.send(v, n);
    sfleb_host_model_inst.end_frame();
    sys_wait(8);
  endtask

  // edges on which the device must keep its outputs released
  task automatic idle(input int n);
    logic [3:0] s;
    logic [3:0] oe;
    for (int e = 0; e < n; e++) begin
      sfleb_host_model_inst.bit_edge(1'b0, 1'b0, s, oe);
      check(oe, `SFLEB_OE_OFF);
    end
  endtask

  // collect bytes and hand each to the watching process
  task automatic read_bytes(input int n, input logic quad);
    logic [3:0] s;
    logic [3:0] oe;
    logic [7:0] b;
    for (int k = 0; k < n; k++) begin
      for (int e = 0; e < (quad ? 2 : 8); e++) begin
        sfleb_host_model_inst.bit_edge(1'b0, 1'b0, s, oe);
        check(oe, quad ? `SFLEB_OE_QUAD : `SFLEB_OE_SER);
        b = quad ? {b[3:0], s} : {b[6:0], s[1]};
      end
      got_byte = b;
      -> byte_ev;
    end
  endtask

  // oldest note against each byte that arrives
  always begin
    @(byte_ev);
    check(got_byte, exp_q.pop_front());
  end

  // load a boot word, stream three bytes, expect the boot to be spent
  task automatic boot_frame(input logic [31:0] w, input logic quad);
    logic [31:0] a;
    @(posedge clk_sys_i);
    bcfg     <= w;
    cfg_load <= 1'b1;
    cr1      <= {6'h00, quad, 1'b0};
    @(posedge clk_sys_i);
    cfg_load <= 1'b0;
    sys_wait(4);
    check(bcfg_rd, w);
    check(armed, 1'b1);
    a = {w[31:9], `SFLEB_BOOT_ALIGN_ZERO};
    for (int k = 0; k < 3; k++) exp_q.push_back(arr_byte(a + k));
    sfleb_host_model_inst.begin_frame();
    idle(w[8:1] + 2);
    read_bytes(3, quad);
    sfleb_host_model_inst.end_frame();
    sys_wait(8);
    check(armed, 1'b0);
  endtask

  // cycle ceiling well above the few hundred cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(91));
    sys_wait(3);
    rst_i <= 1'b0;
    sys_wait(4);
    check(sr1, 8'h00);
    check(bcfg_rd, `SFLEB_BCFG_DEFAULT);
    check(armed, 1'b1);
    req <= 1'b1;
    sys_wait(1);
    check(refuse, 1'b1);
    $display("test reset done");
    cmd({32'h0, `SFLEB_OPC_SET_LATCH}, 8);
    check(sr1, 8'h02);
    check(grant, 1'b1);
    cmd({31'h0, `SFLEB_OPC_CLR_LATCH, 1'b0}, 9);
    check(sr1, 8'h02);
    write_in_progress <= 1'b1;
    cmd({32'h0, `SFLEB_OPC_CLR_LATCH}, 8);
    check(sr1, 8'h03);
    efail_set <= 1'b1;
    pfail_set <= 1'b1;
    sys_wait(1);
    efail_set <= 1'b0;
    pfail_set <= 1'b0;
    sys_wait(3);
    check(sr1, 8'h63);
    cmd({32'h0, `SFLEB_OPC_CLR_ERR}, 8);
    check(sr1, 8'h03);
    // a fail pulse while the enable is low must not land
    ce        <= 1'b0;
    efail_set <= 1'b1;
    sys_wait(1);
    efail_set <= 1'b0;
    ce        <= 1'b1;
    sys_wait(3);
    check(sr1, 8'h03);
    write_in_progress <= 1'b0;
    cmd({32'h0, `SFLEB_OPC_CLR_LATCH}, 8);
    check(sr1, 8'h00);
    check(grant, 1'b0);
    cmd({31'h0, `SFLEB_OPC_SET_LATCH, 1'b1}, 9);
    check(sr1, 8'h00);
    cmd({32'h0, `SFLEB_OPC_SET_LATCH}, 8);
    check(sr1, 8'h02);
    rwdone <= 1'b1;
    sys_wait(1);
    rwdone <= 1'b0;
    sys_wait(3);
    check(sr1, 8'h00);
    $display("test latch and flags done");
    u = 8'($urandom_range(254, 0));
    for (int k = 0; k < 2; k++) begin
      st[k] = 8'($urandom);
      ecc_we   <= 1'b1;
      ecc_unit <= u + 8'(k);
      ecc_stat <= st[k];
      sys_wait(1);
    end
    ecc_we <= 1'b0;
    for (int k = 0; k < 32; k++) exp_q.push_back(st[k / 16]);
    sfleb_host_model_inst.begin_frame();
    sfleb_host_model_inst.send({`SFLEB_OPC_ECC_READ, 20'h00000, u, 4'h0}, 40);
    idle(8);
    read_bytes(32, 1'b0);
    sfleb_host_model_inst.end_frame();
    sys_wait(8);
    $display("test ecc status done");
    boot_frame({23'($urandom), 8'($urandom_range(8, 1)), 1'b1}, 1'b0);
    cmd({32'h0, `SFLEB_OPC_SET_LATCH}, 8);
    check(sr1, 8'h02);
    check(armed, 1'b0);
    soft_rst <= 1'b1;
    sys_wait(1);
    soft_rst <= 1'b0;
    sys_wait(4);
    boot_frame({23'($urandom), 8'h00, 1'b1}, 1'b1);
    $display("test boot stream done");
    end_of_test();
  end
endmodule // serial_flash_latch_ecc_boot_ctrl_tb
